// ### verilog/rsmp_defines.svh
// constants for the repeater serial management port
`ifndef RSMP_DEFINES_SVH
`define RSMP_DEFINES_SVH

// ************************************************
// timing
// ************************************************
`define RSMP_SYS_CLK_KHZ 250000
`define RSMP_MGMT_CLK_KHZ 625
`define RSMP_CLK_HALF_CYC (`RSMP_SYS_CLK_KHZ / (2 * `RSMP_MGMT_CLK_KHZ))
`define RSMP_STRAP_SETTLE 2'h2
`define RSMP_MATCH_HOLD 8'h10

// ************************************************
// message framing
// ************************************************
`define RSMP_START_FLAG 8'h7E
`define RSMP_CFG_ZERO_BITS 16
`define RSMP_TX_BITS 6'h18
`define RSMP_HDR_LAST 3'h7
`define RSMP_IDLE_BITS 4'h8

// ************************************************
// register map and fields
// ************************************************
`define RSMP_REG_CTRL 4'h0
`define RSMP_REG_PORT_EN 4'h1
`define RSMP_REG_HUB_ID 4'h2
`define RSMP_REG_STATUS 4'h3
`define RSMP_REG_CHIP_ID 4'h4
`define RSMP_CTRL_SW_RST 0
`define RSMP_CTRL_LED_HW 1
`define RSMP_CHIP_ID_RST 2'h0
`define RSMP_HUB_ID_RST 8'h00

`endif

// ### verilog/rsmp_pkg.sv
// types shared by the repeater serial management port
package rsmp_pkg;
  typedef enum logic {RSMP_RX_HUNT, RSMP_RX_HDR} rsmp_rx_state_t;
  typedef enum logic [1:0] {RSMP_TX_IDLE, RSMP_TX_SEND, RSMP_TX_BACKOFF} rsmp_tx_state_t;
endpackage

// ### verilog/rsmp_mgmt_port.sv
// serial management port: clock source, message send with readback, hub match, straps
`include "rsmp_defines.svh"

module rsmp_mgmt_port #(
  parameter int NUM_PORTS = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mgmt_clk_pin_i,
  output logic mgmt_clk_pin_o,
  output logic mgmt_clk_pin_oe_o,
  input wire logic clock_source_select_i,
  input wire logic ser_rx_in_i,
  output logic ser_tx_out_o,
  output logic ser_tx_out_oe_o,
  input wire logic arb_chain_in_i,
  output logic arb_chain_out_o,
  input wire logic arbitration_method_strap_i,
  input wire logic local_manager_strap_i,
  output logic hub_match_out_o,
  output logic [NUM_PORTS-1:0] port_enable_o,
  output logic led_hw_mode_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  if (NUM_PORTS < 1 || NUM_PORTS > 8)
  begin : g_chk
    $error("NUM_PORTS must be 1 to 8");
  end

  // ************************************************
  // system clock domain: synchronisers
  // ************************************************
  logic csel_s1, csel_s2, csel_prev;
  logic arbm_s1, arbm_s2;
  logic mgr_s1, mgr_s2;
  logic msg_tgl_reg;
  logic msg_s1, msg_s2, msg_s3;

  // pins and link toggles pass two flops before use
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      csel_s1 <= 1'b0;
      csel_s2 <= 1'b0;
      arbm_s1 <= 1'b0;
      arbm_s2 <= 1'b0;
      mgr_s1 <= 1'b0;
      mgr_s2 <= 1'b0;
      msg_s1 <= 1'b0;
      msg_s2 <= 1'b0;
      msg_s3 <= 1'b0;
    end
    else
    begin
      csel_s1 <= clock_source_select_i;
      csel_s2 <= csel_s1;
      arbm_s1 <= arbitration_method_strap_i;
      arbm_s2 <= arbm_s1;
      mgr_s1 <= local_manager_strap_i;
      mgr_s2 <= mgr_s1;
      msg_s1 <= msg_tgl_reg;
      msg_s2 <= msg_s1;
      msg_s3 <= msg_s2;
    end
  end

  // ************************************************
  // management clock source
  // ************************************************
  logic [8:0] div_cnt_reg;
  logic clk_out_reg, clk_oe_reg;

  // divider runs only while this device owns the clock
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      div_cnt_reg <= 9'h000;
      clk_out_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end
    else
    begin
      clk_oe_reg <= csel_s2;
      if (!csel_s2)
      begin
        div_cnt_reg <= 9'h000;
        clk_out_reg <= 1'b0;
      end
      else if (div_cnt_reg == 9'(`RSMP_CLK_HALF_CYC - 1))
      begin
        div_cnt_reg <= 9'h000;
        clk_out_reg <= ~clk_out_reg;
      end
      else
        div_cnt_reg <= div_cnt_reg + 9'h001;
    end
  end

  assign mgmt_clk_pin_o = clk_out_reg;
  assign mgmt_clk_pin_oe_o = clk_oe_reg;

  // ************************************************
  // configuration change request
  // ************************************************
  logic req_tgl_reg;

  // prev resets low, so a select already high at reset counts as a rise
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      csel_prev <= 1'b0;
      req_tgl_reg <= 1'b0;
    end
    else
    begin
      csel_prev <= csel_s2;
      if (csel_s2 && !csel_prev)
        req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // ************************************************
  // straps and registers
  // ************************************************
  logic [1:0] settle_reg;
  logic mgr_strap_reg, led_hw_reg;
  logic [NUM_PORTS-1:0] port_en_reg;
  logic [7:0] hub_id_reg;
  logic [1:0] chip_id_reg;
  logic sw_rst;

  assign sw_rst = reg_wr_i && reg_addr_i == `RSMP_REG_CTRL && reg_wdata_i[`RSMP_CTRL_SW_RST];

  // strap is caught after the synchroniser settles, after every reset
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      settle_reg <= 2'h0;
      mgr_strap_reg <= 1'b0;
      port_en_reg <= '0;
      led_hw_reg <= 1'b0;
    end
    else if (sw_rst)
      settle_reg <= 2'h0;
    else if (settle_reg != 2'h3)
    begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == `RSMP_STRAP_SETTLE)
      begin
        mgr_strap_reg <= mgr_s2;
        port_en_reg <= mgr_s2 ? '1 : '0;
        led_hw_reg <= mgr_s2;
      end
    end
    else if (reg_wr_i && reg_addr_i == `RSMP_REG_PORT_EN)
      port_en_reg <= reg_wdata_i[NUM_PORTS-1:0];
    else if (reg_wr_i && reg_addr_i == `RSMP_REG_CTRL)
      led_hw_reg <= reg_wdata_i[`RSMP_CTRL_LED_HW];
  end

  // identity registers steering the match logic
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hub_id_reg <= `RSMP_HUB_ID_RST;
      chip_id_reg <= `RSMP_CHIP_ID_RST;
    end
    else if (reg_wr_i && reg_addr_i == `RSMP_REG_HUB_ID)
      hub_id_reg <= reg_wdata_i;
    else if (reg_wr_i && reg_addr_i == `RSMP_REG_CHIP_ID)
      chip_id_reg <= reg_wdata_i[1:0];
  end

  assign port_enable_o = port_en_reg;
  assign led_hw_mode_o = led_hw_reg;

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 8'h00;
    else if (!reg_rd_i)
      reg_rdata_o <= 8'h00;
    else
      unique case (reg_addr_i)
        `RSMP_REG_CTRL: reg_rdata_o <= {6'h00, led_hw_reg, 1'b0};
        `RSMP_REG_PORT_EN: reg_rdata_o <= 8'(port_en_reg);
        `RSMP_REG_HUB_ID: reg_rdata_o <= hub_id_reg;
        `RSMP_REG_STATUS: reg_rdata_o <= {4'h0, csel_s2, arbm_s2, hub_match_out_o, mgr_strap_reg};
        `RSMP_REG_CHIP_ID: reg_rdata_o <= {6'h00, chip_id_reg};
        default: reg_rdata_o <= 8'h00;
      endcase
  end

  // ************************************************
  // hub match indication
  // ************************************************
  logic [7:0] match_cnt_reg;
  logic [7:0] hdr_reg;

  // header word is stable long before its toggle arrives, so read it directly
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      match_cnt_reg <= 8'h00;
      hub_match_out_o <= 1'b0;
    end
    else
    begin
      if ((msg_s2 ^ msg_s3) && chip_id_reg == 2'h0 && hdr_reg == hub_id_reg)
        match_cnt_reg <= `RSMP_MATCH_HOLD;
      else if (match_cnt_reg != 8'h00)
        match_cnt_reg <= match_cnt_reg - 8'h01;
      hub_match_out_o <= (match_cnt_reg != 8'h00);
    end
  end

  // ************************************************
  // link domain: reset and receive
  // ************************************************
  logic lrst_s1, lrst_reg;
  logic rx_bit_reg;
  logic [7:0] rx_sr_reg;
  logic [2:0] hdr_cnt_reg;
  rsmp_pkg::rsmp_rx_state_t rx_state_reg;

  // reset leaves the link domain on its own clock edge
  always_ff @(posedge mgmt_clk_pin_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      lrst_s1 <= 1'b1;
      lrst_reg <= 1'b1;
    end
    else
    begin
      lrst_s1 <= 1'b0;
      lrst_reg <= lrst_s1;
    end
  end

  // hunt for the start flag, then collect the header word
  always_ff @(posedge mgmt_clk_pin_i or posedge lrst_reg)
  begin
    if (lrst_reg)
    begin
      rx_bit_reg <= 1'b1;
      rx_sr_reg <= 8'h00;
      hdr_cnt_reg <= 3'h0;
      hdr_reg <= 8'h00;
      msg_tgl_reg <= 1'b0;
      rx_state_reg <= rsmp_pkg::RSMP_RX_HUNT;
    end
    else
    begin
      rx_bit_reg <= ser_rx_in_i;
      rx_sr_reg <= {rx_sr_reg[6:0], ser_rx_in_i};
      unique case (rx_state_reg)
        rsmp_pkg::RSMP_RX_HUNT:
          if ({rx_sr_reg[6:0], ser_rx_in_i} == `RSMP_START_FLAG)
          begin
            hdr_cnt_reg <= 3'h0;
            rx_state_reg <= rsmp_pkg::RSMP_RX_HDR;
          end
        rsmp_pkg::RSMP_RX_HDR:
          if (hdr_cnt_reg == `RSMP_HDR_LAST)
          begin
            hdr_reg <= {rx_sr_reg[6:0], ser_rx_in_i};
            msg_tgl_reg <= ~msg_tgl_reg;
            rx_state_reg <= rsmp_pkg::RSMP_RX_HUNT;
          end
          else
            hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
      endcase
    end
  end

  // ************************************************
  // link domain: transmit on falling edges
  // ************************************************
  logic rq_s1, rq_s2, rq_s3, arb_s1, arb_s2, am_s1, am_s2;
  logic pending_reg, drive_reg, sent_reg, cur_bit_reg, arb_out_reg;
  logic [`RSMP_CFG_ZERO_BITS+7:0] tx_sr_reg;
  logic [5:0] tx_cnt_reg;
  logic [3:0] idle_cnt_reg;
  rsmp_pkg::rsmp_tx_state_t tx_state_reg;
  logic req_edge;

  assign req_edge = rq_s2 ^ rq_s3;

  // request toggle and chain level cross on the falling edge
  always_ff @(negedge mgmt_clk_pin_i or posedge lrst_reg)
  begin
    if (lrst_reg)
    begin
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_s3 <= 1'b0;
      arb_s1 <= 1'b1;
      arb_s2 <= 1'b1;
      am_s1 <= 1'b0;
      am_s2 <= 1'b0;
    end
    else
    begin
      rq_s1 <= req_tgl_reg;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
      arb_s1 <= arb_chain_in_i;
      arb_s2 <= arb_s1;
      am_s1 <= arbitration_method_strap_i;
      am_s2 <= am_s1;
    end
  end

  // a lost message waits for an idle bus and tries again
  always_ff @(negedge mgmt_clk_pin_i or posedge lrst_reg)
  begin
    if (lrst_reg)
    begin
      pending_reg <= 1'b0;
      drive_reg <= 1'b0;
      sent_reg <= 1'b0;
      cur_bit_reg <= 1'b1;
      tx_sr_reg <= '0;
      tx_cnt_reg <= 6'h00;
      idle_cnt_reg <= 4'h0;
      tx_state_reg <= rsmp_pkg::RSMP_TX_IDLE;
    end
    else
    begin
      unique case (tx_state_reg)
        rsmp_pkg::RSMP_TX_IDLE:
          if (pending_reg && !(am_s2 && arb_s2))
          begin
            tx_sr_reg <= {`RSMP_START_FLAG, {`RSMP_CFG_ZERO_BITS{1'b0}}};
            tx_cnt_reg <= `RSMP_TX_BITS;
            sent_reg <= 1'b0;
            tx_state_reg <= rsmp_pkg::RSMP_TX_SEND;
          end
        rsmp_pkg::RSMP_TX_SEND:
          if (sent_reg && rx_bit_reg != cur_bit_reg)
          begin
            drive_reg <= 1'b0;
            idle_cnt_reg <= 4'h0;
            tx_state_reg <= rsmp_pkg::RSMP_TX_BACKOFF;
          end
          else if (tx_cnt_reg == 6'h00)
          begin
            drive_reg <= 1'b0;
            pending_reg <= 1'b0;
            tx_state_reg <= rsmp_pkg::RSMP_TX_IDLE;
          end
          else
          begin
            cur_bit_reg <= tx_sr_reg[`RSMP_CFG_ZERO_BITS+7];
            drive_reg <= ~tx_sr_reg[`RSMP_CFG_ZERO_BITS+7];
            tx_sr_reg <= {tx_sr_reg[`RSMP_CFG_ZERO_BITS+6:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg - 6'h01;
            sent_reg <= 1'b1;
          end
        rsmp_pkg::RSMP_TX_BACKOFF:
          if (!rx_bit_reg)
            idle_cnt_reg <= 4'h0;
          else if (idle_cnt_reg == `RSMP_IDLE_BITS - 4'h1)
            tx_state_reg <= rsmp_pkg::RSMP_TX_IDLE;
          else
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        default: tx_state_reg <= rsmp_pkg::RSMP_TX_IDLE;
      endcase
      if (req_edge)
        pending_reg <= 1'b1; // a new request beats a completion in the same edge
    end
  end

  // chain passes the grant on only while this device has nothing queued or the arbitration method strap is low
  always_ff @(negedge mgmt_clk_pin_i or posedge lrst_reg)
  begin
    if (lrst_reg)
      arb_out_reg <= 1'b1;
    else
      arb_out_reg <= arb_s2 | (am_s2 & pending_reg);
  end

  assign arb_chain_out_o = arb_out_reg;
  assign ser_tx_out_o = 1'b0;
  assign ser_tx_out_oe_o = drive_reg;

endmodule // rsmp_mgmt_port

// ### tb/rsmp_mgmt_port_props.sv
// concurrent checks on the management port pins
module rsmp_mgmt_port_props #(
  parameter int NUM_PORTS = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mgmt_clk_pin_i,
  input wire logic mgmt_clk_pin_o,
  input wire logic mgmt_clk_pin_oe_o,
  input wire logic clock_source_select_i,
  input wire logic ser_tx_out_o,
  input wire logic ser_tx_out_oe_o,
  input wire logic local_manager_strap_i,
  input wire logic hub_match_out_o,
  input wire logic [NUM_PORTS-1:0] port_enable_o,
  input wire logic led_hw_mode_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic prev_clk;
  logic seen;
  logic [8:0] half_cnt;
  logic [3:0] since_fall;
  logic [4:0] match_len;
  wire tog = mgmt_clk_pin_o != prev_clk;
  // half period counter; the first toggle after enable is not measured
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prev_clk <= 1'b0;
      seen <= 1'b0;
      half_cnt <= 9'h000;
    end
    else
    begin
      prev_clk <= mgmt_clk_pin_o;
      seen <= mgmt_clk_pin_oe_o & (seen | tog);
      half_cnt <= tog ? 9'h000 : half_cnt + 9'h001;
    end
  end
  // cycles since the link clock fell, and length of a match pulse
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      since_fall <= 4'hF;
      match_len <= 5'h00;
    end
    else
    begin
      since_fall <= $fell(mgmt_clk_pin_i) ? 4'h0 : (since_fall == 4'hF ? 4'hF : since_fall + 4'h1);
      match_len <= hub_match_out_o ? match_len + 5'h01 : 5'h00;
    end
  end
  a_oe_tracks_select: assert property (
    $changed(clock_source_select_i) |-> ##[2:4] (mgmt_clk_pin_oe_o == clock_source_select_i))
    else $error("clock pin direction does not follow select");
  a_clk_half_period: assert property (
    mgmt_clk_pin_oe_o && seen && tog |-> half_cnt == 9'h0C7)
    else $error("clock out half period is not 200 cycles");
  a_tx_on_fall: assert property (
    $changed(ser_tx_out_oe_o) |-> $fell(mgmt_clk_pin_i) || since_fall < 4'h8)
    else $error("transmit changed away from a clock fall");
  a_tx_open_drain: assert property (
    ser_tx_out_oe_o |-> !ser_tx_out_o)
    else $error("transmit drives high");
  a_match_hold_len: assert property (
    $fell(hub_match_out_o) |-> match_len == 5'h10)
    else $error("match pulse length wrong");
  a_strap_at_release: assert property (
    $fell(sys_rst_i) |-> ##4 ((port_enable_o == {NUM_PORTS{local_manager_strap_i}})
    && (led_hw_mode_o == local_manager_strap_i)))
    else $error("strap not applied after reset");
  a_strap_at_sw_reset: assert property (
    reg_wr_i && reg_addr_i == 4'h0 && reg_wdata_i[0] |-> ##6
    port_enable_o == {NUM_PORTS{local_manager_strap_i}})
    else $error("strap not applied after software reset");
  a_rdata_idle_zero: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read cycle");
  cover property ($rose(hub_match_out_o));
  cover property ($fell(ser_tx_out_oe_o));
  cover property ($rose(mgmt_clk_pin_oe_o));
endmodule // rsmp_mgmt_port_props

bind rsmp_mgmt_port rsmp_mgmt_port_props #(.NUM_PORTS(NUM_PORTS)) u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .mgmt_clk_pin_i(mgmt_clk_pin_i), .mgmt_clk_pin_o(mgmt_clk_pin_o), .mgmt_clk_pin_oe_o(mgmt_clk_pin_oe_o),
  .clock_source_select_i(clock_source_select_i), .ser_tx_out_o(ser_tx_out_o), .ser_tx_out_oe_o(ser_tx_out_oe_o),
  .local_manager_strap_i(local_manager_strap_i), .hub_match_out_o(hub_match_out_o),
  .port_enable_o(port_enable_o), .led_hw_mode_o(led_hw_mode_o), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

// ### tb/rsmp_bus_far.sv
// far side of the shared serial bus: link clock source and another sender
module rsmp_bus_far (
  input wire logic run_i,
  input wire logic send_i,
  input wire logic jam_i,
  input wire logic dut_oe_i,
  input wire logic [15:0] frame_i,
  output logic link_clk_o,
  output wire logic line_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic pull;
  logic [15:0] sh;
  // wired bus with pull-up; jam holds it low to force a readback clash
  assign line_o = ~(dut_oe_i | pull | jam_i);
  // external clock source rests low while stopped, odd start offset keeps phase unrelated
  always
  begin
    link_clk_o = 1'b0;
    wait (run_i);
    #13.1;
    while (run_i)
    begin
      #32 link_clk_o = ~link_clk_o;
    end
  end
  // frame bits go out msb first on falling edges; one process owns the line state
  initial
  begin
    pull = 1'b0;
    done_o = 1'b0;
    forever
    begin
      @(posedge send_i);
      done_o = 1'b0;
      sh = frame_i;
      repeat (16)
      begin
        @(negedge link_clk_o);
        pull = ~sh[15];
        sh = sh << 1;
      end
      @(negedge link_clk_o);
      pull = 1'b0;
      done_o = 1'b1;
    end
  end
endmodule // rsmp_bus_far

// ### tb/rsmp_mgmt_port_bench.sv
// self-checking bench for the serial management port
module rsmp_mgmt_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, sys_rst_i, csel, arb_in, arb_strap, mgr_strap, reg_wr, reg_rd, run, send, jam;
  logic pin_o, pin_oe, tx_o, tx_oe, arb_out, match, led_hw, link_clk, done;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, rdata, port_en, d;
  logic [15:0] frame;
  logic [31:0] rx_sh = 32'h0;
  wire logic line;
  int fails = 0, total_checks = 0, match_rises = 0, msg_count = 0, oe_rises = 0, r0, m0, n;
  wire logic mgmt_pin = pin_oe ? pin_o : link_clk;
  rsmp_mgmt_port #(.NUM_PORTS(8)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mgmt_clk_pin_i(mgmt_pin),
    .mgmt_clk_pin_o(pin_o), .mgmt_clk_pin_oe_o(pin_oe), .clock_source_select_i(csel), .ser_rx_in_i(line),
    .ser_tx_out_o(tx_o), .ser_tx_out_oe_o(tx_oe), .arb_chain_in_i(arb_in), .arb_chain_out_o(arb_out),
    .arbitration_method_strap_i(arb_strap), .local_manager_strap_i(mgr_strap), .hub_match_out_o(match),
    .port_enable_o(port_en), .led_hw_mode_o(led_hw), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata));
  rsmp_bus_far u_far (.run_i(run), .send_i(send), .jam_i(jam), .dut_oe_i(tx_oe), .frame_i(frame),
    .link_clk_o(link_clk), .line_o(line), .done_o(done));
  // system clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // bus monitor: sees what every device samples on clock rises
  always @(posedge mgmt_pin)
  begin
    rx_sh = {rx_sh[30:0], line};
    if (rx_sh[24:0] == {1'b1, 8'h7E, 16'h0000})
      msg_count++;
    if (tx_oe)
      oe_rises++;
  end
  always @(posedge match) match_rises++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    @(negedge clk_i);
    v = rdata;
  endtask
  // far sender puts a flag plus header on the bus; checks match count
  task automatic send_frame(input logic [15:0] f, input int exp);
    m0 = match_rises;
    @(posedge clk_i);
    frame <= f;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    for (n = 0; n < 3000 && !done; n++) @(posedge clk_i);
    chk({7'h00, done}, 8'h01);
    repeat (40) @(posedge clk_i);
    chk(8'(match_rises - m0), 8'(exp));
  endtask
  task automatic wait_msg();
    for (n = 0; n < 30000 && msg_count == m0; n++) @(posedge clk_i);
    chk(8'(msg_count - m0), 8'h01);
  endtask
  task automatic endtest(input string s);
    $display("test %s done, mismatches so far %0d", s, fails);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #380000;
    fails++;
    $display("FAIL %0t run did not finish", $time);
    close_out();
  end
  // main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    csel = 1'b0;
    arb_in = 1'b0;
    arb_strap = 1'b0;
    mgr_strap = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, run, send, jam, frame} = '0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(port_en, 8'hFF);
    chk({7'h00, led_hw}, 8'h01);
    reg_read(4'h3, d);
    chk(d, 8'h01);
    reg_read(4'hF, d);
    chk(d, 8'h00);
    endtest("power-up straps");
    @(posedge clk_i);
    mgr_strap <= 1'b0;
    arb_strap <= 1'b1;
    reg_write(4'h0, 8'h01);
    repeat (8) @(posedge clk_i);
    chk(port_en, 8'h00);
    reg_read(4'h3, d);
    chk(d, 8'h04);
    @(posedge clk_i);
    arb_strap <= 1'b0;
    reg_write(4'h1, 8'h5A);
    @(negedge clk_i);
    chk(port_en, 8'h5A);
    endtest("software reset");
    run <= 1'b1;
    repeat (160) @(posedge clk_i);
    send_frame(16'h7E00, 1);
    reg_write(4'h2, 8'h21);
    send_frame(16'h7E00, 0);
    send_frame(16'h7E21, 1);
    reg_write(4'h4, 8'h01);
    send_frame(16'h7E21, 0);
    run <= 1'b0;
    endtest("hub match");
    m0 = msg_count;
    csel <= 1'b1;
    wait_msg();
    chk({7'h00, pin_oe}, 8'h01);
    endtest("config message");
    jam <= 1'b1;
    csel <= 1'b0;
    repeat (40) @(posedge clk_i);
    r0 = oe_rises;
    m0 = msg_count;
    csel <= 1'b1;
    for (n = 0; n < 8000 && !(oe_rises != r0 && !tx_oe); n++) @(posedge clk_i);
    repeat (6000) @(posedge clk_i);
    chk(8'(oe_rises - r0), 8'h01);
    jam <= 1'b0;
    wait_msg();
    endtest("readback clash");
    arb_strap <= 1'b1;
    arb_in <= 1'b1;
    csel <= 1'b0;
    repeat (40) @(posedge clk_i);
    m0 = msg_count;
    csel <= 1'b1;
    repeat (12000) @(posedge clk_i);
    chk(8'(msg_count - m0), 8'h00);
    chk({7'h00, arb_out}, 8'h01);
    arb_in <= 1'b0;
    wait_msg();
    repeat (1200) @(posedge clk_i);
    chk({7'h00, arb_out}, 8'h00);
    endtest("chain arbitration");
    close_out();
  end
endmodule // rsmp_mgmt_port_bench
